// ---- logic/pcseq_pkg.sv ----
// constants and types for the program counter sequencer
// assumes a single 125 MHz system clock domain
package pcseq_pkg;
	localparam int PCSEQ_PC_W = 11;
	localparam int PCSEQ_INSTR_W = 14;
	localparam int PCSEQ_STACK_DEPTH = 8;
	localparam int PCSEQ_ROM_WORDS = 2048;
	localparam int PCSEQ_PHASES = 4;
	// register offsets on the data address port
	localparam logic [7:0] PCSEQ_PCL_ADDR = 8'h06;
	localparam logic [7:0] PCSEQ_SCC_ADDR = 8'h1C;
	localparam int PCSEQ_CLKSEL_BIT = 0;
	// 1 selects 12 MHz, 0 selects 6 MHz
	localparam logic PCSEQ_CLKSEL_RST = 1'b1;
	localparam logic [7:0] PCSEQ_PCL_RST = 8'h00;
	// entry points
	localparam logic [10:0] PCSEQ_PC_RST = 11'h000;
	localparam logic [10:0] PCSEQ_VEC_USB = 11'h004;
	localparam logic [10:0] PCSEQ_VEC_TMR = 11'h00C;
	// rates in MHz: base clock 125, system clock 12 or 6
	localparam logic [7:0] PCSEQ_BASE_MHZ = 8'h7D;
	localparam logic [7:0] PCSEQ_RATE_HI_MHZ = 8'h0C;
	localparam logic [7:0] PCSEQ_RATE_LO_MHZ = 8'h06;
	localparam logic [1:0] PCSEQ_LAST_PHASE = 2'h3;
	localparam logic [3:0] PCSEQ_STACK_FULL = 4'h8;

	typedef enum logic [2:0] {
		PCSEQ_OP_SEQ = 3'b000,
		PCSEQ_OP_SKIP = 3'b001,
		PCSEQ_OP_JUMP = 3'b010,
		PCSEQ_OP_CALL = 3'b011,
		PCSEQ_OP_RET = 3'b100,
		PCSEQ_OP_RETURN_FROM_INTERRUPT = 3'b101
	} pcseq_op_t;
endpackage

// ---- logic/pcseq_phase_if.sv ----
// phase timing between the clock divider and the sequencer
// assumes both ends run on clk_sys
`timescale 1ns/10ps
interface pcseq_phase_if;
	logic rate_hi;
	logic sys_tick;
	logic [1:0] phase;
	logic cycle_end;
	modport gen (input rate_hi, output sys_tick, output phase, output cycle_end);
	modport seq (output rate_hi, input sys_tick, input phase, input cycle_end);
endinterface

// ---- logic/pcseq_phase_gen.sv ----
// system clock rate generator and four-phase divider
// assumes clk_sys at 125 MHz, rate_hi from a flop on the same clock
`timescale 1ns/10ps
module pcseq_phase_gen (
	input wire logic clk_sys,
	input wire logic rst,
	pcseq_phase_if.gen ph
);
	import pcseq_pkg::*;

	logic [7:0] acc_q;
	logic [7:0] rate;
	logic [8:0] sum;
	logic wrap;
	logic tick_q;
	logic [1:0] phase_q;
	logic cycle_end_q;

	assign rate = ph.rate_hi ? PCSEQ_RATE_HI_MHZ : PCSEQ_RATE_LO_MHZ;
	assign sum = {1'b0, acc_q} + {1'b0, rate};
	assign wrap = sum >= {1'b0, PCSEQ_BASE_MHZ};

	// fractional accumulator gives exact average rate
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			acc_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			acc_q <= wrap ? 8'(sum - {1'b0, PCSEQ_BASE_MHZ}) : sum[7:0];
			tick_q <= wrap;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phase_q <= 2'h0;
			cycle_end_q <= 1'b0;
		end else begin
			if (wrap) begin
				phase_q <= phase_q + 2'h1;
			end
			cycle_end_q <= wrap && (phase_q == PCSEQ_LAST_PHASE);
		end
	end

	assign ph.sys_tick = tick_q;
	assign ph.phase = phase_q;
	assign ph.cycle_end = cycle_end_q;

	cycle_spacing_a: assert property (@(posedge clk_sys) disable iff (rst) cycle_end_q |=> !cycle_end_q [*8])
		else $error("instruction cycles closer than four system clocks");
	tick_spacing_a: assert property (@(posedge clk_sys) disable iff (rst) tick_q |=> !tick_q [*4])
		else $error("system clock tick faster than 12 MHz");
endmodule

// ---- logic/pcseq_top.sv ----
// program counter sequencer: phases, fetch/execute pipeline, pc, stack, vectors
// assumes ROM answers combinationally on rom_addr, core decodes exec_instr
`timescale 1ns/10ps
module pcseq_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [pcseq_pkg::PCSEQ_PC_W-1:0] rom_addr,
	input wire logic [pcseq_pkg::PCSEQ_INSTR_W-1:0] rom_data,
	output logic [pcseq_pkg::PCSEQ_INSTR_W-1:0] exec_instr,
	output logic exec_valid,
	output logic [1:0] exec_phase,
	input wire pcseq_pkg::pcseq_op_t exec_op,
	input wire logic [pcseq_pkg::PCSEQ_PC_W-1:0] exec_target,
	input wire logic usb_irq_req,
	input wire logic usb_irq_en,
	input wire logic tmr_irq_req,
	input wire logic tmr_irq_en,
	output logic usb_irq_ack,
	output logic tmr_irq_ack,
	output logic [3:0] stack_level
);
	import pcseq_pkg::*;

	localparam int DEPTH = PCSEQ_STACK_DEPTH;

	pcseq_phase_if ph ();

	pcseq_phase_gen u_phase (
		.clk_sys(clk_sys),
		.rst(rst),
		.ph(ph)
	);

	logic clksel_q;
	logic [7:0] rdata_q;
	logic pcl_pend_q;
	logic [7:0] pcl_data_q;
	logic [PCSEQ_PC_W-1:0] pc_q;
	logic [PCSEQ_INSTR_W-1:0] instr_q;
	logic valid_q;
	logic usb_pend_q;
	logic tmr_pend_q;
	logic usb_ack_q;
	logic tmr_ack_q;
	logic [PCSEQ_PC_W-1:0] stack_q [DEPTH];
	logic [2:0] sp_q;
	logic [3:0] level_q;
	logic started_q;
	logic [2:0] tick_cnt_q;

	logic cycle_end;
	logic is_xfer_op;
	logic is_ret_op;
	logic take_xfer;
	logic take_skip;
	logic pcl_go;
	logic stack_full;
	logic irq_ok;
	logic usb_go;
	logic tmr_go;
	logic push;
	logic pop;
	logic [2:0] sp_dec;
	logic [PCSEQ_PC_W-1:0] pc_d;

	assign cycle_end = ph.cycle_end;
	assign ph.rate_hi = clksel_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clksel_q <= PCSEQ_CLKSEL_RST;
		end else if (reg_wr && reg_addr == PCSEQ_SCC_ADDR) begin
			clksel_q <= reg_wdata[PCSEQ_CLKSEL_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd && reg_addr == PCSEQ_PCL_ADDR) begin
			rdata_q <= pc_q[7:0];
		end else if (reg_rd && reg_addr == PCSEQ_SCC_ADDR) begin
			rdata_q <= {7'h00, clksel_q};
		end else begin
			rdata_q <= 8'h00;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pcl_pend_q <= 1'b0;
			pcl_data_q <= PCSEQ_PCL_RST;
		end else if (reg_wr && reg_addr == PCSEQ_PCL_ADDR) begin
			pcl_pend_q <= 1'b1;
			pcl_data_q <= reg_wdata;
		end else if (pcl_go) begin
			pcl_pend_q <= 1'b0;
		end
	end

	assign is_xfer_op = exec_op == PCSEQ_OP_JUMP || exec_op == PCSEQ_OP_CALL || is_ret_op;
	assign is_ret_op = exec_op == PCSEQ_OP_RET || exec_op == PCSEQ_OP_RETURN_FROM_INTERRUPT;
	assign take_xfer = cycle_end && valid_q && is_xfer_op;
	assign take_skip = cycle_end && valid_q && exec_op == PCSEQ_OP_SKIP;
	assign pcl_go = cycle_end && pcl_pend_q && !take_xfer && !take_skip;
	assign stack_full = level_q == PCSEQ_STACK_FULL;
	assign irq_ok = cycle_end && valid_q && !take_xfer && !take_skip && !pcl_go && !stack_full;
	assign usb_go = irq_ok && usb_pend_q && usb_irq_en;
	assign tmr_go = irq_ok && !usb_go && tmr_pend_q && tmr_irq_en;
	assign push = (take_xfer && exec_op == PCSEQ_OP_CALL) || usb_go || tmr_go;
	assign pop = take_xfer && is_ret_op;
	assign sp_dec = sp_q - 3'h1;

	always_comb begin
		pc_d = pc_q;
		if (take_xfer && is_ret_op) begin
			pc_d = stack_q[sp_dec];
		end else if (take_xfer) begin
			pc_d = exec_target;
		end else if (take_skip) begin
			pc_d = pc_q + 11'h001;
		end else if (pcl_go) begin
			pc_d = {pc_q[10:8], pcl_data_q};
		end else if (usb_go) begin
			pc_d = PCSEQ_VEC_USB;
		end else if (tmr_go) begin
			pc_d = PCSEQ_VEC_TMR;
		end else if (cycle_end) begin
			pc_d = pc_q + 11'h001;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pc_q <= PCSEQ_PC_RST;
		end else begin
			pc_q <= pc_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			instr_q <= '0;
			valid_q <= 1'b0;
		end else if (cycle_end) begin
			instr_q <= rom_data;
			valid_q <= !(take_xfer || take_skip || pcl_go || usb_go || tmr_go);
		end
	end

	// request flags: a new request beats the acknowledge clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			usb_pend_q <= 1'b0;
			tmr_pend_q <= 1'b0;
			usb_ack_q <= 1'b0;
			tmr_ack_q <= 1'b0;
		end else begin
			usb_pend_q <= usb_irq_req || (usb_pend_q && !usb_go);
			tmr_pend_q <= tmr_irq_req || (tmr_pend_q && !tmr_go);
			usb_ack_q <= usb_go;
			tmr_ack_q <= tmr_go;
		end
	end

	// circular stack, oldest lost when full
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sp_q <= 3'h0;
			level_q <= 4'h0;
		end else if (push) begin
			sp_q <= sp_q + 3'h1;
			level_q <= stack_full ? level_q : level_q + 4'h1;
		end else if (pop) begin
			sp_q <= sp_dec;
			level_q <= (level_q == 4'h0) ? level_q : level_q - 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			stack_q[sp_q] <= pc_q;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			started_q <= 1'b0;
		end else if (cycle_end) begin
			started_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= 3'h0;
		end else if (cycle_end) begin
			tick_cnt_q <= 3'h0;
		end else if (ph.sys_tick) begin
			tick_cnt_q <= tick_cnt_q + 3'h1;
		end
	end

	assign reg_rdata = rdata_q;
	assign rom_addr = pc_q;
	assign exec_instr = instr_q;
	assign exec_valid = valid_q;
	assign exec_phase = ph.phase;
	assign usb_irq_ack = usb_ack_q;
	assign tmr_irq_ack = tmr_ack_q;
	assign stack_level = level_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	reset_start_a: assert property (!started_q |-> pc_q == PCSEQ_PC_RST && !valid_q)
		else $error("pc not at reset entry before first cycle");
	pc_step_a: assert property (cycle_end && !take_xfer && !take_skip && !pcl_go && !usb_go && !tmr_go
		|=> pc_q == $past(pc_q) + 11'h001 && valid_q)
		else $error("pc did not step by one after fetch");
	pipe_issue_a: assert property (cycle_end && valid_q && exec_op == PCSEQ_OP_SEQ && !pcl_pend_q
		&& !(usb_pend_q && usb_irq_en) && !(tmr_pend_q && tmr_irq_en) |=> valid_q)
		else $error("ordinary instruction stalled the pipe");
	xfer_dummy_a: assert property (take_xfer |=> !valid_q ##1 !valid_q [*8])
		else $error("no dummy cycle after transfer");
	skip_two_a: assert property (take_skip |=> pc_q == $past(pc_q) + 11'h001 && !valid_q)
		else $error("taken skip did not discard fetch");
	pcl_page_a: assert property (pcl_go |=> pc_q == {$past(pc_q[10:8]), $past(pcl_data_q)})
		else $error("short jump left the page");
	usb_vec_a: assert property (usb_go |=> pc_q == PCSEQ_VEC_USB ##0 usb_irq_ack ##1 !usb_irq_ack)
		else $error("usb vector wrong");
	tmr_vec_a: assert property (tmr_go |=> pc_q == PCSEQ_VEC_TMR && tmr_irq_ack && !valid_q)
		else $error("timer vector wrong");
	jump_target_a: assert property (take_xfer && !is_ret_op |=> pc_q == $past(exec_target))
		else $error("jump target not loaded");
	call_full_a: assert property (push && stack_full |=> level_q == PCSEQ_STACK_FULL)
		else $error("stack level moved past eight");
	held_irq_a: assert property (stack_full && !pop |=> !usb_irq_ack && !tmr_irq_ack)
		else $error("interrupt taken with full stack");
	vector_dummy_a: assert property (usb_go || tmr_go |=> !valid_q)
		else $error("vector without dummy cycle");
	phase_zero_a: assert property (cycle_end |-> ph.phase == 2'h0)
		else $error("cycle boundary not at phase zero");
	four_tick_a: assert property (cycle_end |-> ph.sys_tick && tick_cnt_q == 3'(PCSEQ_PHASES - 1))
		else $error("instruction cycle not four system clocks");
	fetch_load_a: assert property (cycle_end |=> exec_instr == $past(rom_data))
		else $error("fetched word not moved to execute");
	ret_pop_a: assert property (take_xfer && is_ret_op |=> pc_q == $past(stack_q[sp_dec]))
		else $error("return did not load top entry");
	pcl_read_a: assert property (reg_rd && reg_addr == PCSEQ_PCL_ADDR |=> reg_rdata == $past(pc_q[7:0]))
		else $error("low pc byte read back wrong");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero without read");
	rate_sel_a: assert property (reg_wr && reg_addr == PCSEQ_SCC_ADDR |=> ph.rate_hi == $past(reg_wdata[PCSEQ_CLKSEL_BIT]))
		else $error("clock select write lost");
	level_bound_a: assert property (level_q <= PCSEQ_STACK_FULL)
		else $error("stack level above eight");
	push_level_a: assert property (push && !stack_full |=> level_q == $past(level_q) + 4'h1)
		else $error("push did not raise stack level");
	pend_hold_a: assert property (usb_pend_q && !usb_go |=> usb_pend_q)
		else $error("usb request lost before service");

	call_cov_c: cover property (take_xfer && exec_op == PCSEQ_OP_CALL);
	ret_cov_c: cover property (take_xfer && exec_op == PCSEQ_OP_RETURN_FROM_INTERRUPT);
	held_cov_c: cover property (stack_full && usb_pend_q && usb_irq_en ##[1:200] usb_go);
	rate_cov_c: cover property (!clksel_q && cycle_end);
	skip_cov_c: cover property (take_skip);
endmodule

// ---- testbench/pcseq_far_model.sv ----
// far side: combinational program ROM and interrupt request sources
// assumes clk_sys domain and fire requests from the bench
`timescale 1ns/10ps
module pcseq_far_model (
	input wire logic clk_sys,
	input wire logic [pcseq_pkg::PCSEQ_PC_W-1:0] rom_addr,
	output logic [pcseq_pkg::PCSEQ_INSTR_W-1:0] rom_data,
	input wire logic fire_usb,
	input wire logic fire_tmr,
	output logic usb_irq_req,
	output logic tmr_irq_req
);
	import pcseq_pkg::*;
	assign rom_data = {3'b101, rom_addr};
	always_ff @(posedge clk_sys) begin
		usb_irq_req <= fire_usb;
		tmr_irq_req <= fire_tmr;
	end
endmodule

// ---- testbench/test_program_counter_sequencer.sv ----
// self-checking bench for the program counter sequencer
// assumes the design files and the far-side model are compiled first
`timescale 1ns/10ps
module test_program_counter_sequencer;
	import pcseq_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [10:0] rom_addr;
	logic [13:0] rom_data;
	logic [13:0] exec_instr;
	logic exec_valid;
	logic [1:0] exec_phase;
	pcseq_op_t exec_op = PCSEQ_OP_SEQ;
	logic [10:0] exec_target = 11'h000;
	logic usb_irq_req, tmr_irq_req, usb_irq_ack, tmr_irq_ack;
	logic usb_irq_en = 1'b1;
	logic tmr_irq_en = 1'b1;
	logic fire_usb = 1'b0;
	logic fire_tmr = 1'b0;
	logic [3:0] stack_level;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int pc, ei, program_counter_low_byte, c;
	bit mv, up, tp, su, st;
	int stk[$];

	pcseq_top i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rom_addr(rom_addr), .rom_data(rom_data),
		.exec_instr(exec_instr), .exec_valid(exec_valid), .exec_phase(exec_phase), .exec_op(exec_op),
		.exec_target(exec_target), .usb_irq_req(usb_irq_req), .usb_irq_en(usb_irq_en),
		.tmr_irq_req(tmr_irq_req), .tmr_irq_en(tmr_irq_en), .usb_irq_ack(usb_irq_ack),
		.tmr_irq_ack(tmr_irq_ack), .stack_level(stack_level));
	pcseq_far_model i_far (.clk_sys(clk_sys), .rom_addr(rom_addr), .rom_data(rom_data), .fire_usb(fire_usb),
		.fire_tmr(fire_tmr), .usb_irq_req(usb_irq_req), .tmr_irq_req(tmr_irq_req));

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		su |= (usb_irq_ack === 1'b1);
		st |= (tmr_irq_ack === 1'b1);
	end

	task automatic summarize;
		if (err_total == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, e});
	endtask
	task automatic edge3;
		int n;
		n = 0;
		while (exec_phase !== 2'h3 && n < 200) begin @(posedge clk_sys); n++; end
		while (exec_phase === 2'h3 && n < 200) begin @(posedge clk_sys); n++; end
		if (n >= 200) begin err_total++; summarize(); end
	endtask
	task automatic fire(input bit u, input bit t);
		@(posedge clk_sys);
		fire_usb <= u;
		fire_tmr <= t;
		@(posedge clk_sys);
		fire_usb <= 1'b0;
		fire_tmr <= 1'b0;
		up |= u;
		tp |= t;
	endtask
	task automatic mreset;
		pc = 0;
		mv = 0;
		up = 0;
		tp = 0;
		program_counter_low_byte = -1;
		stk.delete();
	endtask
	task automatic step(input pcseq_op_t op, input int t);
		bit eu, et;
		eu = 0;
		et = 0;
		exec_op <= op;
		exec_target <= t[10:0];
		su = 0;
		st = 0;
		edge3();
		repeat (6) @(posedge clk_sys);
		if (!mv) begin
			ei = 'h2800 | pc; pc++; mv = 1;
		end else if (op == PCSEQ_OP_JUMP || op == PCSEQ_OP_CALL) begin
			if (op == PCSEQ_OP_CALL && stk.size() == 8) void'(stk.pop_front());
			if (op == PCSEQ_OP_CALL) stk.push_back(pc);
			pc = t; mv = 0;
		end else if (op == PCSEQ_OP_RET || op == PCSEQ_OP_RETURN_FROM_INTERRUPT) begin
			pc = stk.pop_back(); mv = 0;
		end else if (op == PCSEQ_OP_SKIP) begin
			pc++; mv = 0;
		end else if (program_counter_low_byte >= 0) begin
			pc = (pc & 'h700) | program_counter_low_byte; program_counter_low_byte = -1; mv = 0;
		end else if (up && usb_irq_en && stk.size() < 8) begin
			stk.push_back(pc); pc = 'h004; up = 0; eu = 1; mv = 0;
		end else if (tp && tmr_irq_en && stk.size() < 8) begin
			stk.push_back(pc); pc = 'h00C; tp = 0; et = 1; mv = 0;
		end else begin
			ei = 'h2800 | pc; pc++;
		end
		pc = pc & 'h7ff;
		#1 chk(rom_addr, pc[15:0]);
		chk(exec_phase, 16'h0000);
		chk(exec_valid, mv);
		if (mv) chk(exec_instr, ei[15:0]);
		chk(stack_level, stk.size());
		chk(su, eu);
		chk(st, et);
	endtask

	initial begin
		void'($urandom(32'h917f4517));
		mreset();
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		#1 chk(rom_addr, 16'h0000);
		rd(PCSEQ_SCC_ADDR, 8'h01);
		rd(8'h33, 8'h00);
		repeat (3) step(PCSEQ_OP_SEQ, 0);
		rd(PCSEQ_PCL_ADDR, pc[7:0]);
		step(PCSEQ_OP_SEQ, 0);
		c = cyc;
		step(PCSEQ_OP_SEQ, 0);
		chk((cyc - c) inside {[41:42]}, 1);
		wr(PCSEQ_SCC_ADDR, 8'h00);
		rd(PCSEQ_SCC_ADDR, 8'h00);
		step(PCSEQ_OP_SEQ, 0);
		c = cyc;
		step(PCSEQ_OP_SEQ, 0);
		chk((cyc - c) inside {[83:84]}, 1);
		wr(PCSEQ_SCC_ADDR, 8'h01);
		step(PCSEQ_OP_SKIP, 0);
		step(PCSEQ_OP_SEQ, 0);
		step(PCSEQ_OP_CALL, $urandom & 'h7ff);
		step(PCSEQ_OP_SEQ, 0);
		program_counter_low_byte = $urandom & 'hff;
		wr(PCSEQ_PCL_ADDR, program_counter_low_byte[7:0]);
		repeat (2) step(PCSEQ_OP_SEQ, 0);
		step(PCSEQ_OP_JUMP, $urandom & 'h7ff);
		step(PCSEQ_OP_RET, 0);
		step(PCSEQ_OP_SEQ, 0);
		fire(1, 0);
		repeat (2) step(PCSEQ_OP_SEQ, 0);
		step(PCSEQ_OP_RETURN_FROM_INTERRUPT, 0);
		tmr_irq_en <= 1'b0;
		fire(0, 1);
		repeat (2) step(PCSEQ_OP_SEQ, 0);
		tmr_irq_en <= 1'b1;
		repeat (2) step(PCSEQ_OP_SEQ, 0);
		step(PCSEQ_OP_RETURN_FROM_INTERRUPT, 0);
		repeat (9) begin
			step(PCSEQ_OP_CALL, $urandom & 'h7ff);
			step(PCSEQ_OP_SEQ, 0);
		end
		fire(1, 0);
		step(PCSEQ_OP_SEQ, 0);
		step(PCSEQ_OP_RET, 0);
		repeat (3) step(PCSEQ_OP_SEQ, 0);
		wr(PCSEQ_SCC_ADDR, 8'h00);
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		#1 chk({rom_addr, stack_level}, 16'h0000);
		@(posedge clk_sys);
		rst <= 1'b0;
		mreset();
		rd(PCSEQ_SCC_ADDR, 8'h01);
		repeat (2) step(PCSEQ_OP_SEQ, 0);
		summarize();
	end
endmodule
